/* serial_port_pkg.sv */
// Purpose: Shared constants and types for the three-wire serial port
// Assumes: Single system clock domain
// Notes: Control fields follow the nibble layouts of the control registers
package serial_port_pkg;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTL1_RATE_HI_BIT = 3;
  localparam int CTL1_RATE_LO_BIT = 2;
  localparam int CTL1_EDGE_BIT = 1;
  localparam int CTL1_ORDER_BIT = 0;
  localparam int CTL2_START_BIT = 3;
  localparam int CTL2_STATUS_BIT = 2;
  localparam int CTL2_RESYNC_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CTL1_RESET = 4'h0;
  localparam logic [3:0] CTL2_RESET = 4'h0;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [3:0] SHIFT_COUNT = 4'h8;
  localparam logic [1:0] RATE_SLAVE = 2'h0;
  localparam logic [1:0] RATE_QUARTER = 2'h1;
  localparam logic [1:0] RATE_HALF = 2'h2;
  localparam logic [1:0] RATE_FULL = 2'h3;
  localparam int FIFO_DEPTH = 16;
  localparam int BYTE_WIDTH = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clock_rate_select;
    logic shift_edge_select;
    logic bit_order_select;
  } ctl1_type;

  typedef struct packed {
    logic start;
    logic status;
    logic rc_osc_off;
    logic output_resync_select;
  } ctl2_type;

  typedef struct packed {
    logic clock_pin_serial_route;
    logic clock_pin_pwm_route;
    logic dataout_pin_serial_route;
    logic dataout_pin_freq_route;
    logic status_pin_serial_route;
  } route_type;

  typedef struct packed {
    logic clock_pin_output_enable;
    logic dataout_pin_output_enable;
    logic status_pin_output_enable;
  } pin_oe_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b11
  } shift_state_type;

endpackage : serial_port_pkg

/* byte_fifo.sv */
// Purpose: Parameterised synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, clock enable freezes state
// Notes: Stores received bytes until the consumer drains them
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign push = i_ce && i_in_valid && o_in_ready;
  assign pop = i_ce && o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_q];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

/* serial_port.sv */
// Purpose: Three-wire full-duplex 8-bit serial port with pin routing
// Assumes: Pins sampled synchronously to i_clk; writes are one-cycle strobes
// Notes: Received bytes also stream into a 16-word FIFO
// How it works
// - Reset gives slave mode, start/status clear, LSB first, negedge; pin enables follow i_pin_oe.
// - Start set runs exactly eight shifts, in and out together.
// - After the eighth shift raise done request and clear start.
// - Slave ignores pin clock while idle, then uses next eight active edges.
// - Status pin carries start OR status continuously.
// - Master clock comes from one of three prescaler taps.
// - Master drives clock pin only while start; otherwise holds it low.
// - Done flag set once the shift clock is low after the last shift; cleared by any second control write.
// - Done request gated by an interrupt mask bit.
// - Input sampled on rising or falling edge per edge select.
// - Input shifts LSB first or MSB first per order select.
// - Resync off: output changes on shift edge, first bit at start.
// - Resync on: output updates on rising edges, first at first rise.
// - Shift register loaded and read through two nibble registers.
// - Clock pin is output when clock_pin_output_enable is set, in either mode.
// - Clock pin mux: input, shift clock, PWM, or port latch.
// - Data-out mux: port, frequency, serial data, or reset/8kHz/sleep.
// - Both data-out routes set, enable off: drive high under reset strap.
// - Status pin mux: input, ready/select, or port latch.
// - Rate 00 slave, 01 divide by 4, 10 divide by 2, 11 full.
// - First control: rate bits 3:2, edge bit 1, order bit 0.
// - Second control: start bit 3, status bit 2, resync bit 0.
`timescale 1ns/1ps
module serial_port
  import serial_port_pkg::*;
#(
  parameter int FIFO_W = serial_port_pkg::BYTE_WIDTH,
  parameter int FIFO_D = serial_port_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Register writes and read-back
  input wire logic i_ctl1_we,
  input wire logic i_ctl2_we,
  input wire logic i_low_we,
  input wire logic i_high_we,
  input wire logic [3:0] i_wdata,
  output logic [3:0] o_serial_control_first,
  output logic [3:0] o_serial_control_second,
  output logic [3:0] o_shift_low_nibble,
  output logic [3:0] o_shift_high_nibble,
  // Interrupt
  input wire logic i_irq_mask,
  output logic o_transfer_done_irq,
  output logic o_irq_request,
  // Prescaler taps and other pin sources
  input wire logic i_prescaler_tap_full,
  input wire logic i_prescaler_tap_half,
  input wire logic i_prescaler_tap_quarter,
  input wire logic i_pwm_out,
  input wire logic i_freq_out,
  input wire logic i_clk_8khz,
  input wire logic i_sleep,
  input wire logic i_reset_state,
  input wire logic [3:0] i_port_output_latch,
  input wire serial_port_pkg::route_type i_route,
  input wire serial_port_pkg::pin_oe_type i_pin_oe,
  // Pins: serial in, clock, data out, status
  input wire logic i_serial_in_pin,
  input wire logic i_strap_pa0,
  input wire logic i_strap_pa4,
  input wire logic i_clock_pin,
  output logic o_clock_pin,
  output logic o_clock_pin_oe_n,
  output logic o_dataout_pin,
  output logic o_dataout_pin_oe_n,
  output logic o_status_pin,
  output logic o_status_pin_oe_n,
  // Received byte stream
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [FIFO_W-1:0] o_rx_data,
  output logic o_rx_overflow
);
  import serial_port_pkg::*;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  ctl1_type ctl1_q;
  ctl2_type ctl2_q;
  logic [7:0] shreg_q;
  logic [3:0] cnt_q;
  logic done_q;
  logic sout_q;
  logic sclk_q;
  logic ovf_q;
  shift_state_type state_q;

  logic master;
  logic tap_sel;
  logic sclk_src;
  logic rise;
  logic fall;
  logic shift_evt;
  logic last_shift;
  logic last_fall;
  logic [7:0] shreg_shifted;
  logic out_bit;
  logic next_out_bit;
  logic ready_cs;
  logic fifo_in_ready;

  function automatic logic first_bit(input logic [7:0] v, input logic msb);
    first_bit = msb ? v[7] : v[0];
  endfunction : first_bit

  assign master = (ctl1_q.clock_rate_select != RATE_SLAVE);
  assign tap_sel = (ctl1_q.clock_rate_select == RATE_QUARTER)
                   ? i_prescaler_tap_quarter
                   : (ctl1_q.clock_rate_select == RATE_HALF)
                   ? i_prescaler_tap_half
                   : i_prescaler_tap_full;
  // Master clock gated by start; slave clock from the pin
  assign sclk_src = master ? (tap_sel & ctl2_q.start)
                           : i_clock_pin;
  assign rise = sclk_src & ~sclk_q;
  assign fall = ~sclk_src & sclk_q;
  // Idle clock edges are simply dropped
  assign shift_evt = (state_q == ST_SHIFT) &&
                     (ctl1_q.shift_edge_select ? rise : fall);
  assign last_shift = shift_evt && (cnt_q == SHIFT_COUNT - 4'h1);
  assign last_fall = (state_q == ST_DONE) && fall;
  assign shreg_shifted = ctl1_q.bit_order_select
                         ? {shreg_q[6:0], i_serial_in_pin}
                         : {i_serial_in_pin, shreg_q[7:1]};
  assign out_bit = first_bit(shreg_q, ctl1_q.bit_order_select);
  assign next_out_bit = first_bit(shreg_shifted, ctl1_q.bit_order_select);
  assign ready_cs = ctl2_q.start | ctl2_q.status;

  // ----------------------------------------------------------------
  // Register file and shift sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl1_q <= CTL1_RESET;
      ctl2_q <= CTL2_RESET;
      shreg_q <= {NIBBLE_RESET, NIBBLE_RESET};
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      sclk_q <= 1'b0;
      state_q <= ST_IDLE;
    end else if (i_ce) begin
      sclk_q <= sclk_src;
      if (i_ctl1_we) begin
        ctl1_q <= i_wdata;
      end
      if (i_low_we) begin
        shreg_q[3:0] <= i_wdata;
      end
      if (i_high_we) begin
        shreg_q[7:4] <= i_wdata;
      end
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 4'h0;
        end
        ST_SHIFT: begin
          if (shift_evt) begin
            shreg_q <= shreg_shifted;
            cnt_q <= cnt_q + 4'h1;
          end
          if (last_shift) begin
            ctl2_q.start <= 1'b0;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Flag waits only until the shift clock is low after the last shift
          if (last_fall || (fall && ctl1_q.shift_edge_select == 1'b0)
              || !sclk_src) begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
      endcase
      if (i_ctl2_we) begin
        ctl2_q <= i_wdata;
        done_q <= 1'b0;
        state_q <= i_wdata[CTL2_START_BIT] ? ST_SHIFT : ST_IDLE;
        cnt_q <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sout_q <= 1'b0;
    end else if (i_ce) begin
      if (i_ctl2_we && i_wdata[CTL2_START_BIT]) begin
        // Mode of the starting write decides, not the old one
        if (!i_wdata[CTL2_RESYNC_BIT]) begin
          sout_q <= out_bit;
        end
      end else if (!ctl2_q.output_resync_select) begin
        if (shift_evt) begin
          sout_q <= next_out_bit;
        end
      end else if (rise && (state_q != ST_IDLE)) begin
        sout_q <= out_bit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------
  logic clk_out_mux;
  logic [1:0] dout_sel;
  logic dout_strap;
  logic dout_mux;

  assign clk_out_mux = i_route.clock_pin_serial_route
                       ? (master ? sclk_src : 1'b0)
                       : i_route.clock_pin_pwm_route
                       ? i_pwm_out
                       : i_port_output_latch[1];
  assign o_clock_pin = clk_out_mux;
  assign o_clock_pin_oe_n = ~i_pin_oe.clock_pin_output_enable;

  assign dout_sel = {i_route.dataout_pin_serial_route,
                     i_route.dataout_pin_freq_route};
  assign dout_mux = (dout_sel == 2'h0) ? i_port_output_latch[2]
                  : (dout_sel == 2'h1) ? i_freq_out
                  : (dout_sel == 2'h2) ? sout_q
                  : i_reset_state ? 1'b1
                  : i_sleep ? 1'b0
                  : i_clk_8khz;
  assign dout_strap = (dout_sel == 2'h3) && i_reset_state && i_strap_pa0
                      && i_strap_pa4 && !i_clock_pin;
  assign o_dataout_pin = dout_strap ? 1'b1 : dout_mux;
  assign o_dataout_pin_oe_n = ~(i_pin_oe.dataout_pin_output_enable
                                | dout_strap);

  assign o_status_pin = i_route.status_pin_serial_route ? ready_cs
                        : i_port_output_latch[3];
  assign o_status_pin_oe_n = ~i_pin_oe.status_pin_output_enable;

  // ----------------------------------------------------------------
  // Read-back and interrupt
  // ----------------------------------------------------------------
  assign o_serial_control_first = ctl1_q;
  assign o_serial_control_second = ctl2_q;
  assign o_shift_low_nibble = shreg_q[3:0];
  assign o_shift_high_nibble = shreg_q[7:4];
  assign o_transfer_done_irq = done_q;
  assign o_irq_request = done_q & i_irq_mask;

  // ----------------------------------------------------------------
  // Received byte stream
  // ----------------------------------------------------------------
  // Bytes lost to a full FIFO are flagged, never block the link
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ovf_q <= 1'b0;
    end else if (i_ce) begin
      if (last_shift && !fifo_in_ready) begin
        ovf_q <= 1'b1;
      end else if (i_ctl2_we) begin
        ovf_q <= 1'b0;
      end
    end
  end
  assign o_rx_overflow = ovf_q;

  byte_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_rx_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_in_valid(last_shift),
    .o_in_ready(fifo_in_ready),
    .i_in_data(shreg_shifted[FIFO_W-1:0]),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data(o_rx_data)
  );
endmodule : serial_port

/* serial_port_chk_sva.sv */
// Purpose: Port-level checks for the serial port
// Assumes: One clock domain, asynchronous high reset
// Notes: Pin muxes are combinational, so most checks are same-cycle
`timescale 1ns/1ps
module serial_port_chk
  import serial_port_pkg::*;
(
  // Clock, reset, writes
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ctl2_we,
  input wire logic i_low_we,
  input wire logic i_high_we,
  // Sources and pin setup
  input wire logic i_irq_mask,
  input wire logic i_prescaler_tap_full,
  input wire logic i_prescaler_tap_half,
  input wire logic i_prescaler_tap_quarter,
  input wire logic i_pwm_out,
  input wire logic i_freq_out,
  input wire logic i_clk_8khz,
  input wire logic i_sleep,
  input wire logic i_reset_state,
  input wire logic i_strap_pa0,
  input wire logic i_strap_pa4,
  input wire logic i_clock_pin,
  input wire logic [3:0] i_port_output_latch,
  input wire serial_port_pkg::route_type i_route,
  input wire serial_port_pkg::pin_oe_type i_pin_oe,
  // Design outputs
  input wire logic [3:0] o_serial_control_first,
  input wire logic [3:0] o_serial_control_second,
  input wire logic [3:0] o_shift_low_nibble,
  input wire logic [3:0] o_shift_high_nibble,
  input wire logic o_transfer_done_irq,
  input wire logic o_irq_request,
  input wire logic o_clock_pin,
  input wire logic o_clock_pin_oe_n,
  input wire logic o_dataout_pin,
  input wire logic o_dataout_pin_oe_n,
  input wire logic o_status_pin,
  input wire logic o_status_pin_oe_n
);
  // --------------------------------------------------------------
  // Derived levels
  // --------------------------------------------------------------
  wire logic st = o_serial_control_second[CTL2_START_BIT];
  wire logic [1:0] rate = o_serial_control_first[3:2];
  wire logic tap = (rate == RATE_FULL) ? i_prescaler_tap_full :
    (rate == RATE_HALF) ? i_prescaler_tap_half : i_prescaler_tap_quarter;
  wire logic [7:0] nib = {o_shift_high_nibble, o_shift_low_nibble};
  wire pin_oe_type oe = i_pin_oe;
  wire route_type rt = i_route;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_done_clears_start:
    assert property ($rose(o_transfer_done_irq) |-> !st)
    else $error("start still set when done rose");
  a_irq_mask_gate:
    assert property (o_irq_request == (o_transfer_done_irq & i_irq_mask))
    else $error("request not done gated by mask");
  a_start_write_clear:
    assert property (i_ctl2_we |=> !o_transfer_done_irq)
    else $error("done flag survived a control write");
  a_done_flag_stands:
    assert property (o_transfer_done_irq && !i_ctl2_we |=> o_transfer_done_irq)
    else $error("done flag dropped on its own");
  a_idle_data_hold:
    assert property (!st && !i_low_we && !i_high_we && !i_ctl2_we
      |=> $stable(nib))
    else $error("shift data moved while idle");
  a_ready_follows:
    assert property (!o_status_pin_oe_n && rt.status_pin_serial_route
      |-> o_status_pin == (st | o_serial_control_second[CTL2_STATUS_BIT]))
    else $error("ready pin is not start or status");
  a_status_mux_path:
    assert property (o_status_pin_oe_n == !oe.status_pin_output_enable &&
      (rt.status_pin_serial_route || o_status_pin_oe_n ||
      o_status_pin == i_port_output_latch[3]))
    else $error("status pin mux wrong");
  a_master_clock:
    assert property (oe.clock_pin_output_enable && rt.clock_pin_serial_route
      && rate != RATE_SLAVE |-> o_clock_pin == (st & tap))
    else $error("master clock not tap gated by start");
  a_clock_mux_path:
    assert property (o_clock_pin_oe_n == !oe.clock_pin_output_enable &&
      (rt.clock_pin_serial_route || o_clock_pin_oe_n || o_clock_pin ==
      (rt.clock_pin_pwm_route ? i_pwm_out : i_port_output_latch[1])))
    else $error("clock pin mux wrong");
  a_dataout_mux_path:
    assert property (oe.dataout_pin_output_enable &&
      !rt.dataout_pin_serial_route |-> !o_dataout_pin_oe_n && o_dataout_pin
      == (rt.dataout_pin_freq_route ? i_freq_out : i_port_output_latch[2]))
    else $error("data out pin mux wrong");
  a_strap_drive_high:
    assert property (rt.dataout_pin_serial_route && rt.dataout_pin_freq_route
      && i_reset_state && i_strap_pa0 && i_strap_pa4 && !i_clock_pin
      |-> !o_dataout_pin_oe_n && o_dataout_pin)
    else $error("strap did not drive data out high");
  a_dataout_special:
    assert property (oe.dataout_pin_output_enable &&
      rt.dataout_pin_serial_route && rt.dataout_pin_freq_route |->
      !o_dataout_pin_oe_n && o_dataout_pin == (i_reset_state ||
      (!i_sleep && i_clk_8khz)))
    else $error("data out reset or clock output wrong");
endmodule : serial_port_chk

bind serial_port serial_port_chk chk (.*);

/* serial_peer.sv */
// Purpose: Far-side serial peer for the bench
// Assumes: Select is the status pin; the peer clock idles low
// Notes: Data moves three cycles after a fall, clear of both samples
`timescale 1ns/1ps
module serial_peer (
  // Clock and pins seen
  input wire logic i_clk,
  input wire logic i_sel,
  input wire logic i_sclk,
  input wire logic i_sdo,
  // Pins driven
  output logic o_sclk,
  output logic o_sdi
);
  logic [7:0] tx_q = 8'h00;
  logic [7:0] rx_q = 8'h00;
  int idx = 0;
  initial o_sclk = 1'b0;
  initial o_sdi = 1'b0;
  // --------------------------------------------------------------
  // Data towards the device, LSB first
  // --------------------------------------------------------------
  always @(posedge i_sel) idx = 0;
  always @(negedge i_sclk) begin
    if (i_sel === 1'b1) begin
      repeat (3) @(posedge i_clk);
      idx = idx + 1;
    end
  end
  // Outside a frame the line toggles so stale data never looks valid
  always @(posedge i_clk) begin
    if (i_sel === 1'b1 && idx < 8) o_sdi <= tx_q[idx[2:0]];
    else o_sdi <= ~o_sdi;
  end
  // Slave-mode clock source; samples device data away from its edge
  task automatic burst(input int n, input logic late);
    for (int k = 0; k < n; k++) begin
      repeat (5) @(posedge i_clk);
      if (late) rx_q[k[2:0]] = i_sdo;
      o_sclk <= 1'b1;
      repeat (5) @(posedge i_clk);
      if (!late) rx_q[k[2:0]] = i_sdo;
      o_sclk <= 1'b0;
    end
    repeat (5) @(posedge i_clk);
  endtask : burst
endmodule : serial_peer

/* testbench.sv */
// Purpose: Self-checking bench for the serial port
// Assumes: Peer clocks slave transfers; taps come from a local counter
// Notes: Expected bytes queue at the driver, a monitor pops them
`timescale 1ns/1ps
module testbench;
  import serial_port_pkg::*;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1, i_irq_mask = 1'b0;
  logic [3:0] we = 4'h0, i_wdata = 4'h0, cnt = 4'h0;
  logic i_pwm_out = 1'b0, i_freq_out = 1'b0, i_clk_8khz = 1'b0;
  logic i_sleep = 1'b0, i_reset_state = 1'b0, i_strap_pa0 = 1'b0;
  logic i_strap_pa4 = 1'b0, i_rx_ready = 1'b0, done_q = 1'b0;
  logic [3:0] i_port_output_latch = 4'h0;
  route_type i_route = '0;
  pin_oe_type i_pin_oe = '0;
  logic [3:0] o_serial_control_first, o_serial_control_second;
  logic [3:0] o_shift_low_nibble, o_shift_high_nibble;
  logic o_transfer_done_irq, o_irq_request, o_clock_pin, o_clock_pin_oe_n;
  logic o_dataout_pin, o_dataout_pin_oe_n, o_status_pin, o_status_pin_oe_n;
  logic o_rx_valid, o_rx_overflow, i_serial_in_pin, peer_clk;
  logic [7:0] o_rx_data, tx, exp;
  logic [31:0] rnd = 32'hB3815116;
  int err_total = 0;
  int checks_done = 0;
  logic [7:0] nq[$];
  logic [7:0] fq[$];
  wire logic i_ctl1_we = we[0];
  wire logic i_ctl2_we = we[1];
  wire logic i_low_we = we[2];
  wire logic i_high_we = we[3];
  wire logic i_prescaler_tap_full = cnt[1];
  wire logic i_prescaler_tap_half = cnt[2];
  wire logic i_prescaler_tap_quarter = cnt[3];
  wire logic i_clock_pin = o_clock_pin_oe_n ? peer_clk : o_clock_pin;
  wire logic sel = !o_status_pin_oe_n && o_status_pin;
  wire logic [2:0] oen = {o_clock_pin_oe_n, o_dataout_pin_oe_n,
    o_status_pin_oe_n};

  serial_port uut (.*);
  serial_peer peer (.i_clk(i_clk), .i_sel(sel), .i_sclk(i_clock_pin),
    .i_sdo(o_dataout_pin), .o_sclk(peer_clk), .o_sdi(i_serial_in_pin));

  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) cnt <= cnt + 4'h1;
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev8[k] = v[7 - k];
  endfunction : rev8
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input int s, input logic [3:0] d);
    we[s] <= 1'b1;
    i_wdata <= d;
    @(posedge i_clk);
    we <= 4'h0;
    @(posedge i_clk);
  endtask : wr
  task automatic wait_done();
    for (int n = 0; n < 400 && o_transfer_done_irq !== 1'b1; n++) begin
      @(posedge i_clk);
    end
  endtask : wait_done
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // --------------------------------------------------------------
  // Monitor and watchdog
  // --------------------------------------------------------------
  always @(posedge i_clk) begin
    done_q <= o_transfer_done_irq;
    if (o_transfer_done_irq === 1'b1 && done_q === 1'b0 && nq.size() > 0)
      check({o_shift_high_nibble, o_shift_low_nibble}, nq.pop_front());
    if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1 && fq.size() > 0)
      check(o_rx_data, fq.pop_front());
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    tally_and_finish();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    check({o_serial_control_first, o_serial_control_second}, 8'h00);
    check(oen, 8'h07);
    // Enable low must block a first control write
    i_ce <= 1'b0;
    wr(0, 4'hF);
    check(o_serial_control_first, 4'h0);
    i_ce <= 1'b1;
    i_pin_oe <= 3'b011;
    i_route <= 5'b00101;
    // Seventeen slave transfers fill the stalled buffer past its depth
    for (int i = 0; i < 17; i++) begin
      rnd = lfsr(rnd);
      tx = rnd[7:0];
      peer.tx_q = rnd[15:8];
      i_irq_mask <= rnd[16];
      exp = i[1] ? rev8(rnd[15:8]) : rnd[15:8];
      nq.push_back(exp);
      if (i < 16) fq.push_back(exp);
      wr(0, {2'b00, i[0], i[1]});
      check(o_serial_control_first, {2'b00, i[0], i[1]});
      wr(2, tx[3:0]);
      wr(3, tx[7:4]);
      peer.burst(2, 1'b0);
      wr(1, {3'b100, i[2]});
      peer.burst(8, i[0] & ~i[2]);
      wait_done();
      check(o_transfer_done_irq, 1'b1);
      check(o_irq_request, i_irq_mask);
      check(o_serial_control_second, {3'b000, i[2]});
      check(peer.rx_q, i[1] ? rev8(tx) : tx);
    end
    check(o_rx_overflow, 1'b1);
    repeat (80) begin
      rnd = lfsr(rnd);
      i_rx_ready <= rnd[0];
      @(posedge i_clk);
    end
    check(8'(fq.size()), 8'h00);
    check(o_rx_valid, 1'b0);
    i_pin_oe <= 3'b111;
    i_route <= 5'b10101;
    for (int r = 1; r < 4; r++) begin
      rnd = lfsr(rnd);
      peer.tx_q = rnd[7:0];
      nq.push_back(rnd[7:0]);
      wr(0, {r[1:0], 2'b00});
      wr(1, 4'h8);
      wait_done();
      check(o_transfer_done_irq, 1'b1);
      check(o_clock_pin, 1'b0);
    end
    // Mid-run reset must restore the defaults
    i_sys_rst <= 1'b1;
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    check({o_serial_control_first, o_serial_control_second}, 8'h00);
    check(o_transfer_done_irq, 1'b0);
    check(o_rx_valid, 1'b0);
    wr(1, 4'h4);
    check(o_status_pin, 1'b1);
    repeat (60) begin
      rnd = lfsr(rnd);
      {i_route, i_pin_oe, i_port_output_latch, i_pwm_out, i_freq_out,
        i_clk_8khz, i_sleep, i_reset_state, i_strap_pa0,
        i_strap_pa4} <= rnd[18:0];
      @(posedge i_clk);
    end
    i_route <= 5'b00110;
    i_pin_oe <= 3'b000;
    i_reset_state <= 1'b1;
    i_strap_pa0 <= 1'b1;
    i_strap_pa4 <= 1'b1;
    @(posedge i_clk);
    check({o_dataout_pin, o_dataout_pin_oe_n}, 2'b10);
    tally_and_finish();
  end
endmodule : testbench
